//--- core/cpmc_defs.vh
/*
  Constants of the clock and power mode controller: register offsets,
  reset values, field positions and counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef CPMC_DEFS_VH
`define CPMC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CPMC_A_LOCK   8'h00
`define CPMC_A_MPLL   8'h04
`define CPMC_A_USB_PLL   8'h08
`define CPMC_A_GATE   8'h0C
`define CPMC_A_SLOW   8'h10
`define CPMC_A_RATIO  8'h14
`define CPMC_A_STAT   8'h18
`define CPMC_A_XMSK   8'h1C
`define CPMC_A_XPND   8'h20

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CPMC_LOCK_RST  32'h00FF_FFFF
`define CPMC_MPLL_RST  32'h0005_C080
`define CPMC_USB_PLL_RST  32'h0002_8080
`define CPMC_GATE_RST  32'h0000_FFF0
`define CPMC_SLOW_RST  32'h0000_0000
`define CPMC_XMSK_RST  24'hFF_FFFF
`define CPMC_ZERO      32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CPMC_B_IDLE    2
`define CPMC_B_POFF    3
`define CPMC_B_GPIO    4
`define CPMC_B_SLOW    4
`define CPMC_B_MOFF    5
`define CPMC_B_UOFF    7
`define CPMC_B_PHALF   0
`define CPMC_B_BHALF   1
`define CPMC_F_MLOCK   11:0
`define CPMC_F_ULOCK   23:12
`define CPMC_F_SVAL    2:0
`define CPMC_F_GATES   15:4

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
// Wake-up reset: crystal periods, the crystal being hclk here
`define CPMC_WAKE_CNT  16'hFFFF
`define CPMC_RATIO_DEF 2'h0

`endif

//--- core/cpmc_top.v
/*
  Clock and power mode controller: core, bus, peripheral and USB clock
  enables, PLL lock sequencing, slow mode and power modes, AHB-Lite slave.
  Assumes hclk is the crystal/external input clock, pll_tick and
  usb_pll_tick are one-cycle enables on hclk from the PLL models, and
  every generated clock is a one-cycle enable pulse.
*/
// The address map and register access over AHB-Lite were decided locally.
// Function
// - Outside slow mode, core clock held stopped while the main PLL locks after reprogramming.
// - After reset core clock is the crystal until PLL config is written.
// - Lock starts on config write; core switches to PLL when lock ends.
// - In normal mode a divider write starts lock with core, bus and peripheral clocks stopped; USB clock runs on.
// - USB clock is crystal until configured or when off; low while locking.
// - Two ratio bits give core:bus:peripheral 1:1:1, 1:1:2, 1:2:2, 1:2:4.
// - Ratio written during lock applies at lock end; survives wake-up resets and modes.
// - Ratio applies after 1.5 bus clocks, or 1 bus clock from default.
// - Halved bus in fast bus mode runs the processor from the bus clock.
// - Normal and slow clock everything; idle stops processor; power-off stops all.
// - Idle keeps bus clocked; exits on external line (GPIO clock on), RTC alarm, other irq.
// - Slow core clock is crystal divided by 1, or 2n for code n.
// - Slow bus and peripheral clocks follow the ratio; USB clock unchanged.
// - Leaving slow with PLL off inserts a lock, slow clock kept meanwhile.
// - Setting slow bit with PLL running selects slow clock, PLL stays on.
// - Clearing slow bit after lock switches to PLL at once.
// - Clearing slow and PLL-off together keeps slow clock until lock ends.
// - Power-off wakes on external lines 15:0 or RTC alarm.
// - Masked source still wakes, but sets its pending bit only if unmasked.
// - Idle request bit enters idle only after processor acknowledge.
// - Wake-up from power-off holds internal reset 65535 crystal periods.
`timescale 1ns/100ps
`include "cpmc_defs.vh"

module cpmc_top #(
  parameter [15:0] WAKE_RST_CYC = `CPMC_WAKE_CNT
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // PLL output ticks, on hclk
  input  wire        pll_tick,
  input  wire        usb_pll_tick,
  // Processor side, on hclk
  input  wire        idle_ack,
  input  wire        fast_bus_mode,
  input  wire        other_irq,
  // Wake-up pins, asynchronous
  input  wire [23:0] external_interrupt_line,
  input  wire        rtc_alarm,
  // Clock enables
  output reg         core_clk_en,
  output reg         cpu_clk_en,
  output reg         bus_clk_en,
  output reg         periph_clk_en,
  output reg         usb_clk_en,
  output reg  [11:0] periph_gate,
  // Power control
  output reg         main_pll_pd,
  output reg         usb_pll_pd,
  output reg         idle_req,
  output reg         power_en,
  output reg         int_reset_n,
  output reg         cpu_on_bus_clk
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_NORM = 3'b000;
  localparam [2:0] ST_IREQ = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_POFF = 3'b011;
  localparam [2:0] ST_WRST = 3'b100;

  function sel_is;
    input [31:0] a;
    input [7:0]  off;
    begin
      sel_is = (a[7:0] == off) && (a[31:8] == 24'h00_0000);
    end
  endfunction

  function [3:0] slow_div;
    input [2:0] v;
    begin
      slow_div = (v == 3'h0) ? 4'h1 : {v, 1'b0};
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] lock_r;
  reg [31:0] mpll_r;
  reg [31:0] usb_pll_r;
  reg [31:0] gate_r;
  reg [31:0] slow_r;
  reg [23:0] xmsk_r;
  reg [23:0] xpnd_r;
  reg [1:0]  ratio_act_r;
  reg [1:0]  ratio_new_r;
  reg        ratio_pend_r;
  reg        ratio_wait_r;
  reg        wr_r;
  reg [31:0] wa_r;
  reg [2:0]  st_r;
  reg        pll_used_r;
  reg        locking_r;
  reg        slow_hold_r;
  reg [11:0] lock_cnt_r;
  reg        usb_cfgd_r;
  reg        usb_lock_r;
  reg [11:0] ulock_cnt_r;
  reg [3:0]  slow_cnt_r;
  reg        bus_ph_r;
  reg        per_ph_r;
  reg [15:0] wake_cnt_r;
  reg [23:0] ext_m_r;
  reg [23:0] ext_s_r;
  reg [23:0] ext_d_r;
  reg        rtc_m_r;
  reg        rtc_s_r;

  wire wen = wr_r;
  wire [31:0] wd = hwdata;
  wire w_lock = wen && sel_is(wa_r, `CPMC_A_LOCK);
  wire w_mpll = wen && sel_is(wa_r, `CPMC_A_MPLL);
  wire w_usb_pll = wen && sel_is(wa_r, `CPMC_A_USB_PLL);
  wire w_gate = wen && sel_is(wa_r, `CPMC_A_GATE);
  wire w_slow = wen && sel_is(wa_r, `CPMC_A_SLOW);
  wire w_ratio = wen && sel_is(wa_r, `CPMC_A_RATIO);
  wire w_xmsk = wen && sel_is(wa_r, `CPMC_A_XMSK);
  wire w_xpnd = wen && sel_is(wa_r, `CPMC_A_XPND);

  wire slow_bit = slow_r[`CPMC_B_SLOW];
  wire moff_bit = slow_r[`CPMC_B_MOFF];
  wire uoff_bit = slow_r[`CPMC_B_UOFF];
  wire bus_halve_bit = ratio_act_r[`CPMC_B_BHALF];
  wire periph_halve_bit = ratio_act_r[`CPMC_B_PHALF];
  wire powered = (st_r != ST_POFF) && (st_r != ST_WRST);

  // Leaving slow with the PLL off needs a fresh lock first
  wire slow_exit_lock = w_slow && slow_bit && moff_bit && !wd[`CPMC_B_MOFF];
  wire lock_start = w_mpll || slow_exit_lock;
  wire lock_done = locking_r && (lock_cnt_r == 12'h000);

  // ----------------------------------------------------------------
  // Clock enable generation
  // ----------------------------------------------------------------
  wire slow_tick = (slow_cnt_r == 4'h0);
  wire use_slow = slow_bit || slow_hold_r;
  reg  core_tick;

  always @* begin
    if (!powered) begin
      core_tick = 1'b0;
    end else if (use_slow) begin
      core_tick = slow_tick;
    end else if (locking_r) begin
      core_tick = 1'b0;
    end else if (pll_used_r) begin
      core_tick = pll_tick;
    end else begin
      core_tick = 1'b1;
    end
  end

  wire bus_tick = core_tick && (!bus_halve_bit || bus_ph_r);
  wire per_tick = bus_tick && (!periph_halve_bit || per_ph_r);
  wire usb_tick = (uoff_bit || !usb_cfgd_r) ? powered :
                  (usb_lock_r ? 1'b0 : usb_pll_tick);

  // ----------------------------------------------------------------
  // Wake-up sources
  // ----------------------------------------------------------------
  wire gpio_on = gate_r[`CPMC_B_GPIO];
  wire [23:0] ext_rise = ext_s_r & ~ext_d_r;
  wire wake_idle = (|(ext_s_r & {24{gpio_on}})) || rtc_s_r || other_irq;
  wire wake_off = (|ext_s_r[15:0]) || rtc_s_r;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_m_r <= 24'h00_0000;
      ext_s_r <= 24'h00_0000;
      ext_d_r <= 24'h00_0000;
      rtc_m_r <= 1'b0;
      rtc_s_r <= 1'b0;
    end else begin
      ext_m_r <= external_interrupt_line;
      ext_s_r <= ext_m_r;
      ext_d_r <= ext_s_r;
      rtc_m_r <= rtc_alarm;
      rtc_s_r <= rtc_m_r;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  wire take = hsel && htrans[1] && hready;
  reg [31:0] rd_nxt;

  always @* begin
    if (sel_is(haddr, `CPMC_A_LOCK)) begin
      rd_nxt = lock_r;
    end else if (sel_is(haddr, `CPMC_A_MPLL)) begin
      rd_nxt = mpll_r;
    end else if (sel_is(haddr, `CPMC_A_USB_PLL)) begin
      rd_nxt = usb_pll_r;
    end else if (sel_is(haddr, `CPMC_A_GATE)) begin
      rd_nxt = gate_r;
    end else if (sel_is(haddr, `CPMC_A_SLOW)) begin
      rd_nxt = slow_r;
    end else if (sel_is(haddr, `CPMC_A_RATIO)) begin
      rd_nxt = {30'h0000_0000, ratio_act_r};
    end else if (sel_is(haddr, `CPMC_A_STAT)) begin
      rd_nxt = {24'h00_0000, usb_lock_r, locking_r, pll_used_r, use_slow, 1'b0, st_r};
    end else if (sel_is(haddr, `CPMC_A_XMSK)) begin
      rd_nxt = {8'h00, xmsk_r};
    end else if (sel_is(haddr, `CPMC_A_XPND)) begin
      rd_nxt = {8'h00, xpnd_r};
    end else begin
      rd_nxt = `CPMC_ZERO;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      wa_r <= `CPMC_ZERO;
      hrdata <= `CPMC_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_r <= take && hwrite;
      if (take) begin
        wa_r <= haddr;
      end
      if (take && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_r <= `CPMC_LOCK_RST;
      mpll_r <= `CPMC_MPLL_RST;
      usb_pll_r <= `CPMC_USB_PLL_RST;
      slow_r <= `CPMC_SLOW_RST;
      xmsk_r <= `CPMC_XMSK_RST;
      xpnd_r <= 24'h00_0000;
    end else begin
      if (w_lock) begin
        lock_r <= wd;
      end
      if (w_mpll) begin
        mpll_r <= wd;
      end
      if (w_usb_pll) begin
        usb_pll_r <= wd;
      end
      if (w_slow) begin
        slow_r <= wd;
      end
      if (w_xmsk) begin
        xmsk_r <= wd[23:0];
      end
      // Set wins over a write-one clear in the same cycle
      xpnd_r <= (xpnd_r & ~(w_xpnd ? wd[23:0] : 24'h00_0000)) | (ext_rise & ~xmsk_r);
    end
  end

  // ----------------------------------------------------------------
  // Main and USB PLL lock sequencing
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_used_r <= 1'b0;
      locking_r <= 1'b0;
      slow_hold_r <= 1'b0;
      lock_cnt_r <= 12'h000;
      usb_cfgd_r <= 1'b0;
      usb_lock_r <= 1'b0;
      ulock_cnt_r <= 12'h000;
    end else if (!powered) begin
      // Wake-up restarts from the crystal, like a power-on reset
      pll_used_r <= 1'b0;
      locking_r <= 1'b0;
      slow_hold_r <= 1'b0;
      usb_cfgd_r <= 1'b0;
      usb_lock_r <= 1'b0;
    end else begin
      if (lock_start) begin
        locking_r <= 1'b1;
        lock_cnt_r <= lock_r[`CPMC_F_MLOCK];
        slow_hold_r <= slow_exit_lock && !wd[`CPMC_B_SLOW];
      end else if (lock_done) begin
        locking_r <= 1'b0;
        pll_used_r <= 1'b1;
        slow_hold_r <= 1'b0;
      end else if (locking_r) begin
        lock_cnt_r <= lock_cnt_r - 12'h001;
      end
      if (w_usb_pll) begin
        usb_cfgd_r <= 1'b1;
        usb_lock_r <= 1'b1;
        ulock_cnt_r <= lock_r[`CPMC_F_ULOCK];
      end else if (usb_lock_r && (ulock_cnt_r == 12'h000)) begin
        usb_lock_r <= 1'b0;
      end else if (usb_lock_r) begin
        ulock_cnt_r <= ulock_cnt_r - 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slow divider and ratio dividers
  // ----------------------------------------------------------------
  // Divider value and ratio change only at a tick, so no short phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt_r <= 4'h0;
      bus_ph_r <= 1'b0;
      per_ph_r <= 1'b0;
      ratio_act_r <= `CPMC_RATIO_DEF;
      ratio_new_r <= `CPMC_RATIO_DEF;
      ratio_pend_r <= 1'b0;
      ratio_wait_r <= 1'b0;
    end else begin
      if (slow_tick) begin
        slow_cnt_r <= slow_div(slow_r[`CPMC_F_SVAL]) - 4'h1;
      end else begin
        slow_cnt_r <= slow_cnt_r - 4'h1;
      end
      if (core_tick) begin
        bus_ph_r <= !bus_ph_r && bus_halve_bit;
      end
      if (bus_tick) begin
        per_ph_r <= !per_ph_r && periph_halve_bit;
      end
      if (w_ratio) begin
        ratio_new_r <= wd[1:0];
        ratio_pend_r <= 1'b1;
        ratio_wait_r <= 1'b0;
      end else if (ratio_pend_r && !locking_r) begin
        if ((ratio_wait_r && core_tick) ||
            (bus_tick && (ratio_act_r == `CPMC_RATIO_DEF))) begin
          ratio_act_r <= ratio_new_r;
          ratio_pend_r <= 1'b0;
          ratio_wait_r <= 1'b0;
          bus_ph_r <= 1'b0;
          per_ph_r <= 1'b0;
        end else if (bus_tick) begin
          ratio_wait_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Power mode sequencer
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= ST_NORM;
      gate_r <= `CPMC_GATE_RST;
      wake_cnt_r <= 16'h0000;
    end else begin
      if (w_gate) begin
        gate_r <= wd;
      end
      case (st_r)
        ST_NORM: begin
          if (gate_r[`CPMC_B_POFF]) begin
            st_r <= ST_POFF;
          end else if (gate_r[`CPMC_B_IDLE]) begin
            st_r <= ST_IREQ;
          end
        end
        ST_IREQ: begin
          if (idle_ack) begin
            st_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (wake_idle) begin
            st_r <= ST_NORM;
            gate_r[`CPMC_B_IDLE] <= 1'b0;
          end
        end
        ST_POFF: begin
          if (wake_off) begin
            st_r <= ST_WRST;
            wake_cnt_r <= WAKE_RST_CYC;
            gate_r[`CPMC_B_POFF] <= 1'b0;
          end
        end
        ST_WRST: begin
          if (wake_cnt_r == 16'h0001) begin
            st_r <= ST_NORM;
          end
          wake_cnt_r <= wake_cnt_r - 16'h0001;
        end
        default: begin
          st_r <= ST_NORM;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_clk_en <= 1'b0;
      cpu_clk_en <= 1'b0;
      bus_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      usb_clk_en <= 1'b0;
      periph_gate <= 12'h000;
      main_pll_pd <= 1'b0;
      usb_pll_pd <= 1'b0;
      idle_req <= 1'b0;
      power_en <= 1'b1;
      int_reset_n <= 1'b1;
      cpu_on_bus_clk <= 1'b0;
    end else begin
      core_clk_en <= core_tick;
      // Processor follows the bus clock in fast bus mode when halved
      cpu_clk_en <= (st_r != ST_IDLE) &&
                    (cpu_on_bus_clk ? bus_tick : core_tick);
      bus_clk_en <= bus_tick;
      periph_clk_en <= per_tick;
      usb_clk_en <= usb_tick;
      periph_gate <= powered ? gate_r[`CPMC_F_GATES] : 12'h000;
      main_pll_pd <= slow_bit && moff_bit && !slow_hold_r;
      usb_pll_pd <= uoff_bit;
      idle_req <= (st_r == ST_IREQ);
      power_en <= powered;
      int_reset_n <= (st_r != ST_WRST);
      cpu_on_bus_clk <= bus_halve_bit && fast_bus_mode;
    end
  end

endmodule // cpmc_top

//--- tb/cpmc_top_properties.sv
/*
  Port-level checker for the clock and power mode controller.
  Assumes it is bound to cpmc_top and that hclk is the only clock.
*/
`timescale 1ns/100ps
module cpmc_top_props #(
  parameter [15:0] WAKE_RST_CYC = 16'hFFFF
) (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Watched ports
  input wire        hreadyout,
  input wire        hresp,
  input wire        fast_bus_mode,
  input wire        idle_ack,
  input wire        core_clk_en,
  input wire        cpu_clk_en,
  input wire        bus_clk_en,
  input wire [11:0] periph_gate,
  input wire        idle_req,
  input wire        power_en,
  input wire        int_reset_n,
  input wire        cpu_on_bus_clk
);
  // ----------------------------------------------------------------
  // Wake reset length
  // ----------------------------------------------------------------
  // Counts sampled low cycles, so the full figure stays off the repetition
  reg [15:0] low_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      low_r <= 16'h0000;
    else if (int_reset_n)
      low_r <= 16'h0000;
    else
      low_r <= low_r + 16'h0001;
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  cpu_core_a: assert property (cpu_clk_en |-> core_clk_en)
    else $error("processor clock pulse without core pulse");
  idle_ack_a: assert property ($fell(idle_req) |-> $past(idle_ack))
    else $error("idle request dropped without acknowledge");
  wake_len_a: assert property ($rose(int_reset_n) |-> low_r == WAKE_RST_CYC)
    else $error("wake reset length wrong");
  wake_from_off_a: assert property ($fell(int_reset_n) |-> $past(power_en) == 1'b0)
    else $error("internal reset outside power-off");
  rst_power_a: assert property (!int_reset_n |-> !power_en)
    else $error("power enabled during wake reset");
  cpu_bus_a: assert property (cpu_on_bus_clk |-> $past(fast_bus_mode))
    else $error("processor on bus clock outside fast bus mode");
  poff_gate_a: assert property (!power_en && int_reset_n |-> periph_gate == 12'h000)
    else $error("peripheral gates open in power-off");
  poff_clk_a: assert property (!power_en && int_reset_n && $past(int_reset_n)
    |-> !core_clk_en && !bus_clk_en)
    else $error("clock pulse in power-off");

  wake_c: cover property ($rose(int_reset_n));
  idle_c: cover property ($fell(idle_req));
  half_c: cover property ($rose(cpu_on_bus_clk));
endmodule // cpmc_top_props

bind cpmc_top cpmc_top_props #(.WAKE_RST_CYC(WAKE_RST_CYC)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .fast_bus_mode(fast_bus_mode), .idle_ack(idle_ack), .core_clk_en(core_clk_en),
  .cpu_clk_en(cpu_clk_en), .bus_clk_en(bus_clk_en), .periph_gate(periph_gate),
  .idle_req(idle_req), .power_en(power_en), .int_reset_n(int_reset_n),
  .cpu_on_bus_clk(cpu_on_bus_clk)
);

//--- tb/cpmc_top_tb.sv
/*
  Self-checking bench for the clock and power mode controller.
  Assumes this module is the only bus master and makes the PLL ticks.
*/
`timescale 1ns/100ps
`include "cpmc_defs.vh"
module cpmc_top_tb;
  localparam [15:0] WAKE = 16'h0010;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0000_0000;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0000_0000;
  reg         pll_tick = 1'b0;
  reg         usb_pll_tick = 1'b0;
  reg         pll_hi = 1'b0;
  reg         idle_ack = 1'b0;
  reg         fast_bus_mode = 1'b1;
  reg         other_irq = 1'b0;
  reg  [23:0] ext_line = 24'h00_0000;
  reg         rtc_alarm = 1'b0;
  reg  [31:0] q;
  wire [31:0] hrdata;
  wire [11:0] periph_gate;
  wire        hreadyout, hresp, core_clk_en, cpu_clk_en, bus_clk_en, periph_clk_en;
  wire        usb_clk_en, main_pll_pd, usb_pll_pd, idle_req, power_en, int_reset_n;
  wire        cpu_on_bus_clk;
  integer     error_cnt, n_tests, cyc, k;
  integer     c_core, c_cpu, c_bus, c_per, c_usb;

  cpmc_top #(.WAKE_RST_CYC(WAKE)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pll_tick(pll_tick),
    .usb_pll_tick(usb_pll_tick), .idle_ack(idle_ack), .fast_bus_mode(fast_bus_mode),
    .other_irq(other_irq), .external_interrupt_line(ext_line), .rtc_alarm(rtc_alarm),
    .core_clk_en(core_clk_en), .cpu_clk_en(cpu_clk_en), .bus_clk_en(bus_clk_en),
    .periph_clk_en(periph_clk_en), .usb_clk_en(usb_clk_en), .periph_gate(periph_gate),
    .main_pll_pd(main_pll_pd), .usb_pll_pd(usb_pll_pd), .idle_req(idle_req),
    .power_en(power_en), .int_reset_n(int_reset_n), .cpu_on_bus_clk(cpu_on_bus_clk)
  );

  // ----------------------------------------------------------------
  // Clock, PLL ticks and timeout
  // ----------------------------------------------------------------
  always #20 hclk = ~hclk;
  // PLLs tick every other cycle, the main PLL every cycle while pll_hi is set, so PLL and crystal rates can differ
  always @(posedge hclk) begin
    pll_tick <= pll_hi | ~pll_tick;
    usb_pll_tick <= ~usb_pll_tick;
  end
  initial cyc = 0;
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdchk(input [7:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0000_0000);
      chk(q, e);
    end
  endtask

  task cnt(input integer n);
    begin
      c_core = 0; c_cpu = 0; c_bus = 0; c_per = 0; c_usb = 0;
      repeat (n) begin
        @(posedge hclk);
        #1;
        c_core = c_core + core_clk_en;
        c_cpu = c_cpu + cpu_clk_en;
        c_bus = c_bus + bus_clk_en;
        c_per = c_per + periph_clk_en;
        c_usb = c_usb + usb_clk_en;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    begin
      rdchk(`CPMC_A_LOCK, `CPMC_LOCK_RST);
      rdchk(`CPMC_A_MPLL, `CPMC_MPLL_RST);
      rdchk(`CPMC_A_USB_PLL, `CPMC_USB_PLL_RST);
      rdchk(`CPMC_A_GATE, `CPMC_GATE_RST);
      rdchk(`CPMC_A_SLOW, `CPMC_SLOW_RST);
      rdchk(`CPMC_A_XMSK, {8'h00, `CPMC_XMSK_RST});
      wr(8'h40, 32'hA5A5_A5A5);
      rdchk(8'h40, `CPMC_ZERO);
    end
  endtask

  task t_lock;
    begin
      cnt(20);
      chk(c_core, 20);
      chk(c_usb, 20);
      wr(`CPMC_A_LOCK, 32'h0000_5005);
      pll_hi <= 1'b1;
      wr(`CPMC_A_MPLL, `CPMC_MPLL_RST);
      cnt(30);
      chk(c_core, 24);
      chk(c_bus, 24);
      pll_hi <= 1'b0;
      repeat (4) @(posedge hclk);
      cnt(20);
      chk(c_core, 10);
      wr(`CPMC_A_USB_PLL, `CPMC_USB_PLL_RST);
      repeat (30) @(posedge hclk);
      cnt(20);
      chk(c_usb, 10);
    end
  endtask

  task t_ratio;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wr(`CPMC_A_RATIO, k);
        repeat (10) @(posedge hclk);
        cnt(40);
        chk(c_core, 20);
        chk(c_bus, k[1] ? 10 : 20);
        chk(c_per, (k == 0) ? 20 : (k == 3) ? 5 : 10);
        chk(cpu_on_bus_clk, k[1]);
      end
    end
  endtask

  task t_slow;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        wr(`CPMC_A_SLOW, 32'h0000_0010 | k);
        repeat (40) @(posedge hclk);
        cnt(1680);
        chk(c_core, (k == 0) ? 1680 : 840 / k);
        chk(c_bus, (k == 0) ? 840 : 420 / k);
        chk(main_pll_pd, 0);
      end
      wr(`CPMC_A_SLOW, `CPMC_ZERO);
      repeat (2) @(posedge hclk);
      cnt(20);
      chk(c_core, 10);
    end
  endtask

  task t_exit;
    begin
      wr(`CPMC_A_LOCK, 32'h0000_5028);
      wr(`CPMC_A_SLOW, 32'h0000_00B0);
      repeat (10) @(posedge hclk);
      chk(main_pll_pd, 1);
      chk(usb_pll_pd, 1);
      wr(`CPMC_A_SLOW, `CPMC_ZERO);
      repeat (2) @(posedge hclk);
      cnt(20);
      chk(c_core, 20);
      repeat (40) @(posedge hclk);
      cnt(20);
      chk(c_core, 10);
      chk(main_pll_pd, 0);
    end
  endtask

  task t_idle;
    begin
      fast_bus_mode <= 1'b0;
      for (k = 0; k < 2; k = k + 1) begin
        wr(`CPMC_A_GATE, 32'h0000_FFF4);
        repeat (4) @(posedge hclk);
        chk(idle_req, 1);
        chk(cpu_on_bus_clk, 0);
        cnt(8);
        chk(c_cpu, 4);
        idle_ack <= 1'b1;
        repeat (4) @(posedge hclk);
        cnt(20);
        chk(c_cpu, 0);
        chk(c_bus, 5);
        if (k == 1)
          ext_line[20] <= 1'b1;
        else
          other_irq <= 1'b1;
        repeat (8) @(posedge hclk);
        ext_line <= 24'h00_0000;
        other_irq <= 1'b0;
        idle_ack <= 1'b0;
        cnt(20);
        chk(c_cpu, 10);
        rdchk(`CPMC_A_GATE, `CPMC_GATE_RST);
      end
    end
  endtask

  task t_poff;
    integer i;
    begin
      wr(`CPMC_A_XMSK, 32'h00FF_FFFE);
      for (i = 0; i < 3; i = i + 1) begin
        wr(`CPMC_A_GATE, 32'h0000_FFF8);
        repeat (4) @(posedge hclk);
        chk(power_en, 0);
        chk(periph_gate, 0);
        if (i == 2)
          rtc_alarm <= 1'b1;
        else
          ext_line[i] <= 1'b1;
        k = 0;
        while (int_reset_n !== 1'b0 && k < 20) begin
          @(posedge hclk);
          #1;
          k = k + 1;
        end
        chk(int_reset_n, 0);
        ext_line <= 24'h00_0000;
        rtc_alarm <= 1'b0;
        k = 0;
        while (int_reset_n === 1'b0 && k < 40) begin
          @(posedge hclk);
          #1;
          k = k + 1;
        end
        chk(k, WAKE);
        chk(power_en, 1);
        rdchk(`CPMC_A_XPND, (i == 0) ? 32'h0000_0001 : 32'h0000_0000);
        wr(`CPMC_A_XPND, 32'h00FF_FFFF);
      end
      rdchk(`CPMC_A_RATIO, 32'h0000_0003);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_lock;
    t_ratio;
    t_slow;
    t_exit;
    t_idle;
    t_poff;
    stop_test;
  end
endmodule // cpmc_top_tb
